//--- sarr_top.sv
`timescale 1ns/10ps
`default_nettype none
module sarr_top (
   // Clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Serial pins
   input wire logic conversion_start_pin,
   input wire logic din_pin,
   input wire logic sclk_pin,
   output logic dout_o,
   output logic dout_oe,
   // Converter core
   output logic sample_req,
   output logic conv_busy,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [sarr_pkg::DATA_W-1:0] sample_data
);
   import sarr_pkg::*;

   logic [2:0] cv_sync_q;
   logic [2:0] din_sync_q;
   logic [2:0] sck_sync_q;
   logic cv_s;
   logic din_s;
   logic conv_rise;
   logic conv_fall;
   logic din_rise;
   logic din_fall;
   logic sclk_fall;
   sarr_state_type state_q;
   sarr_state_type state_d;
   logic [CONV_CNT_W-1:0] cnt_q;
   logic [CONV_CNT_W-1:0] cnt_d;
   logic [BIT_CNT_W-1:0] bits_q;
   logic [BIT_CNT_W-1:0] bits_d;
   logic [DATA_W-1:0] shreg_q;
   logic [DATA_W-1:0] shreg_d;
   logic daisy_q;
   logic daisy_d;
   logic src_din_q;
   logic src_din_d;
   logic oe_q;
   logic oe_d;
   logic req_q;
   logic req_d;
   logic fifo_valid;
   logic fifo_pop;
   logic [DATA_W-1:0] fifo_data;

   // Bit 0 feeds bit 1 only; edges compare bits 1 and 2
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cv_sync_q <= 3'h7;
         din_sync_q <= 3'h7;
         sck_sync_q <= 3'h0;
      end else if (clk_en) begin
         cv_sync_q <= {cv_sync_q[1:0], conversion_start_pin};
         din_sync_q <= {din_sync_q[1:0], din_pin};
         sck_sync_q <= {sck_sync_q[1:0], sclk_pin};
      end
   end

   assign cv_s = cv_sync_q[1];
   assign din_s = din_sync_q[1];
   assign conv_rise = cv_s && !cv_sync_q[2];
   assign conv_fall = !cv_s && cv_sync_q[2];
   assign din_rise = din_s && !din_sync_q[2];
   assign din_fall = !din_s && din_sync_q[2];
   assign sclk_fall = !sck_sync_q[1] && sck_sync_q[2];

   sarr_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Result waits in the conversion state until the core has delivered it
   assign fifo_pop = (state_q == SARR_CONV)
      && (cnt_q >= CONV_CNT_W'(CONV_CYC - 1));

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bits_d = bits_q;
      shreg_d = shreg_q;
      daisy_d = daisy_q;
      src_din_d = src_din_q;
      oe_d = oe_q;
      req_d = 1'b0;
      if (conv_rise && state_q != SARR_CONV) begin
         oe_d = 1'b0;
         daisy_d = !din_s;
         cnt_d = '0;
         req_d = 1'b1;
         state_d = SARR_CONV;
      end else begin
         unique case (state_q)
            SARR_CONV: begin
               if (cnt_q < CONV_CNT_W'(CONV_CYC - 1)) begin
                  cnt_d = cnt_q + 1'b1;
               end else if (fifo_valid) begin
                  shreg_d = fifo_data;
                  bits_d = '0;
                  state_d = SARR_ACQ;
               end
            end
            SARR_ACQ: begin
               if (conv_fall && (daisy_q || din_s)) begin
                  oe_d = 1'b1;
                  src_din_d = 1'b0;
                  state_d = SARR_READ;
               end else if (!daisy_q && din_fall && cv_s) begin
                  oe_d = 1'b1;
                  src_din_d = 1'b1;
                  state_d = SARR_READ;
               end
            end
            SARR_READ: begin
               if (!daisy_q && src_din_q && din_rise) begin
                  oe_d = 1'b0;
                  state_d = SARR_ACQ;
               end else if (sclk_fall) begin
                  // Chain data enters at the bottom as the result leaves
                  shreg_d = {shreg_q[DATA_W-2:0], din_s};
                  bits_d = bits_q + 1'b1;
                  if (!daisy_q && bits_q == BIT_CNT_W'(DATA_W - 1)) begin
                     oe_d = 1'b0;
                     state_d = SARR_ACQ;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SARR_ACQ;
         cnt_q <= '0;
         bits_q <= '0;
         shreg_q <= RESULT_RESET;
         daisy_q <= 1'b0;
         src_din_q <= 1'b0;
         oe_q <= 1'b0;
         req_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bits_q <= bits_d;
         shreg_q <= shreg_d;
         daisy_q <= daisy_d;
         src_din_q <= src_din_d;
         oe_q <= oe_d;
         req_q <= req_d;
      end
   end

   // Edge detection costs three clocks, so pin delays are far above the
   // nanosecond figures of a real converter; sclk must stay below clk/4
   assign dout_o = shreg_q[DATA_W-1];
   assign dout_oe = oe_q;
   assign sample_req = req_q;
   assign conv_busy = state_q == SARR_CONV;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_start_floats: assert property (clk_en && conv_rise |=> !dout_oe)
      else $error("output not floated on start rise");
   a_mode_latch: assert property (clk_en && conv_rise
      && state_q != SARR_CONV
      |=> state_q == SARR_CONV && daisy_q == !$past(din_s))
      else $error("mode not latched on start rise");
   a_three_wire_en: assert property (clk_en && state_q == SARR_ACQ
      && conv_fall && din_s && !daisy_q
      |=> dout_oe && dout_o == $past(shreg_q[DATA_W-1]))
      else $error("start fall did not present msb");
   // A start rise in the same cycle wins over the select fall
   a_four_wire_en: assert property (clk_en && state_q == SARR_ACQ
      && !daisy_q && din_fall && cv_s && !conv_rise
      |=> dout_oe && src_din_q)
      else $error("select fall did not enable output");
   a_select_release: assert property (clk_en
      && state_q == SARR_READ && !daisy_q && src_din_q && din_rise
      |=> !dout_oe)
      else $error("select rise did not float output");
   a_shift_next: assert property (clk_en && state_q == SARR_READ
      && sclk_fall && !conv_rise && !(src_din_q && din_rise)
      |=> shreg_q == {$past(shreg_q[DATA_W-2:0]), $past(din_s)})
      else $error("output did not advance on clock fall");
   a_daisy_capture: assert property (clk_en && state_q == SARR_READ
      && daisy_q && sclk_fall && !conv_rise
      |=> dout_oe && shreg_q[0] == $past(din_s))
      else $error("chain input not captured");
   a_last_edge_float: assert property (clk_en
      && state_q == SARR_READ && !daisy_q && sclk_fall && !conv_rise
      && bits_q == BIT_CNT_W'(DATA_W - 1)
      |=> !dout_oe && state_q == SARR_ACQ)
      else $error("output still driven after last bit");
   a_conv_timed: assert property (clk_en && state_q == SARR_CONV
      && cnt_q < CONV_CNT_W'(CONV_CYC - 1) |=> state_q == SARR_CONV)
      else $error("conversion ended early");
   a_msb_first: assert property (clk_en && fifo_pop && fifo_valid
      && !conv_rise |=> shreg_q == $past(fifo_data))
      else $error("result not loaded msb first");

   c_three_wire: cover property (state_q == SARR_READ && !daisy_q
      && !src_din_q ##1 state_q == SARR_ACQ);
   c_four_wire: cover property (state_q == SARR_READ && src_din_q
      ##1 state_q == SARR_ACQ);
   c_daisy_read: cover property (state_q == SARR_READ && daisy_q
      && sclk_fall);
   c_fifo_full: cover property (!sample_ready);
endmodule
`default_nettype wire

//--- sarr_pkg.sv
package sarr_pkg;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 50;
   // Longest conversion time; rounded down to whole cycles
   localparam int CONV_TIME_NS = 8800;
   localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = $clog2(CONV_CYC + 1);
   localparam int BIT_CNT_W = $clog2(DATA_W);
   localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
   typedef enum logic [1:0] {
      SARR_ACQ,
      SARR_CONV,
      SARR_READ
   } sarr_state_type;
endpackage

//--- sarr_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sarr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] wr_d;
   logic [AW:0] rd_q;
   logic [AW:0] rd_d;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = wr_q != rd_q;
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready && clk_en;
   assign pop = out_valid && out_ready && clk_en;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         wr_d = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // Storage has no reset; only words behind the write pointer are read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- sarr_host.sv
`timescale 1ns/10ps
`default_nettype none
module sarr_host
   import sarr_pkg::*;
(
   // Clocking
   input wire logic clk,
   // Pins driven
   output logic start_o,
   output logic din_o,
   output logic sclk_o,
   // Pins watched
   input wire logic dout_o,
   input wire logic dout_oe,
   // Received words and the output enable seen after start
   output logic rx_stb,
   output logic [sarr_pkg::DATA_W-1:0] rx_word,
   output logic oe_seen
);
   logic last_q;
   logic line;
   // A floating line shows the inverse of its last value
   assign line = dout_oe ? dout_o : ~last_q;
   always @(posedge clk) begin
      if (dout_oe) begin
         last_q <= dout_o;
      end
   end
   initial begin
      start_o = 1'b1;
      din_o = 1'b1;
      sclk_o = 1'b0;
      rx_stb = 1'b0;
      rx_word = '0;
      oe_seen = 1'b0;
      last_q = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Host times the conversion itself and does not watch conv_busy
   task automatic convert(input int m);
      din_o <= (m != 2);
      start_o <= 1'b0;
      wt(4);
      start_o <= 1'b1;
      wt(5);
      @(negedge clk) oe_seen = dout_oe;
      wt(190);
   endtask
   task automatic read(input int m, input int n, input logic [DATA_W-1:0] p);
      logic [DATA_W-1:0] w;
      w = '0;
      if (m == 1) begin
         din_o <= 1'b0;
      end else begin
         start_o <= 1'b0;
      end
      wt(6);
      for (int i = 0; i < n; i++) begin
         sclk_o <= 1'b1;
         if (m == 2) begin
            din_o <= p[15 - (i % 16)];
         end
         wt(3);
         @(negedge clk) w = {w[DATA_W-2:0], line};
         @(posedge clk);
         sclk_o <= 1'b0;
         rx_stb <= (i % 16 == 15);
         rx_word <= w;
         @(posedge clk) rx_stb <= 1'b0;
         wt(3);
      end
      // Deselect after a 4-wire read; held high until the next start
      if (m == 1) begin
         din_o <= 1'b1;
      end
      wt(3);
   endtask
endmodule
`default_nettype wire

//--- sarr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sarr_top_tb;
   import sarr_pkg::*;
   logic clk, rst_n, clk_en, sample_valid, start, din, sclk, dout_o, dout_oe;
   logic sample_req, conv_busy, sample_ready, rx_stb, oe_seen;
   logic [DATA_W-1:0] sample_data, rx_word, d, pat;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] fifo_q[$];
   int n_errors, n_checks, n_req, i, k;
   sarr_top sarr_top_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .conversion_start_pin(start), .din_pin(din), .sclk_pin(sclk),
      .dout_o(dout_o), .dout_oe(dout_oe), .sample_req(sample_req),
      .conv_busy(conv_busy), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_data(sample_data));
   sarr_host sarr_host_i (.clk(clk), .start_o(start), .din_o(din),
      .sclk_o(sclk), .dout_o(dout_o), .dout_oe(dout_oe), .rx_stb(rx_stb),
      .rx_word(rx_word), .oe_seen(oe_seen));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string what, input logic [DATA_W-1:0] seen,
         input logic [DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic timeout(input string what);
      n_errors++;
      $display("[FAIL] %s expected done seen timeout", what);
      end_of_test();
   endtask
   // Valid is held until ready is seen before the taking edge
   task automatic push(input logic [DATA_W-1:0] v);
      int n;
      n = 0;
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_data <= v;
      @(negedge clk);
      while (sample_ready !== 1'b1 && n < 400) begin
         n++;
         @(negedge clk);
      end
      if (n >= 400) timeout("push");
      @(posedge clk);
      sample_valid <= 1'b0;
   endtask
   always @(negedge clk) begin
      if (rx_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("[FAIL] rx_word expected none seen %h", rx_word);
         end else begin
            check("rx_word", rx_word, exp_q.pop_front());
         end
      end
   end
   // Every accepted start rise asks the core for one sample
   always @(negedge clk) begin
      if (sample_req === 1'b1) begin
         n_req++;
      end
   end
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      n_req = 0;
      sample_valid = 1'b0;
      sample_data = '0;
      n_errors = 0;
      n_checks = 0;
      void'($urandom(80324));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < FIFO_DEPTH; i++) begin
         d = DATA_W'($urandom);
         push(d);
         fifo_q.push_back(d);
      end
      // No conversion has run, so nothing drains the buffer yet
      @(negedge clk) check("fifo_full", sample_ready, 1'b0);
      $display("test fill done");
      for (i = 0; i < FIFO_DEPTH; i++) begin
         k = i % 3;
         sarr_host_i.convert(k);
         check("oe_after_start", oe_seen, 1'b0);
         check("busy_done", conv_busy, 1'b0);
         d = fifo_q.pop_front();
         pat = DATA_W'($urandom);
         if (i == 3 || i == 4) begin
            // Cut short: 3-wire keeps driving until the next start rise,
            // 4-wire floats on the select rise
            sarr_host_i.read(k, 5, pat);
            @(negedge clk) check("oe_cut", dout_oe, k == 0);
         end else begin
            exp_q.push_back(d);
            if (k == 2) exp_q.push_back(pat);
            sarr_host_i.read(k, (k == 2) ? 32 : 16, pat);
            @(negedge clk) check("oe_end", dout_oe, k == 2);
         end
         $display("test mode %0d read %0d done", k, i);
      end
      sarr_host_i.convert(0);
      check("busy_empty", conv_busy, 1'b1);
      d = DATA_W'($urandom);
      // A frozen block must neither take a word nor leave the conversion
      clk_en <= 1'b0;
      push(~d);
      repeat (4) @(negedge clk);
      check("busy_frozen", conv_busy, 1'b1);
      clk_en <= 1'b1;
      push(d);
      for (k = 0; k < 20 && conv_busy !== 1'b0; k++) @(negedge clk);
      if (k >= 20) timeout("conv_busy");
      exp_q.push_back(d);
      sarr_host_i.read(0, 16, '0);
      @(negedge clk) check("oe_end", dout_oe, 1'b0);
      check("rx_all", DATA_W'(exp_q.size()), '0);
      check("req_count", DATA_W'(n_req), DATA_W'(FIFO_DEPTH + 1));
      $display("test drain done");
      end_of_test();
   end
endmodule
`default_nettype wire
